/* rtl/gdm_pkg.sv */
// Purpose: Shared constants for the GPIO drive mode and auxiliary input block.
// Assumes: Avalon-MM word addressing with byte offsets equal to four times the register index.
// Notes: Port data registers sit at index 0x00 and 0x01 beside the documented map.
package gdm_pkg;
  localparam int          GDM_AW           = 6;
  localparam int          GDM_DW           = 32;
  localparam int          GDM_PW           = 8;
  localparam logic [7:0]  GDM_IDX_P0_DATA  = 8'h00;
  localparam logic [7:0]  GDM_IDX_P1_DATA  = 8'h01;
  localparam logic [7:0]  GDM_IDX_AUX      = 8'h02;
  localparam logic [7:0]  GDM_IDX_P0_CFG_A = 8'h0A;
  localparam logic [7:0]  GDM_IDX_P0_CFG_B = 8'h0B;
  localparam logic [7:0]  GDM_IDX_P1_CFG_A = 8'h0C;
  localparam logic [7:0]  GDM_IDX_P1_CFG_B = 8'h0D;
  localparam logic [7:0]  GDM_IDX_MODE     = 8'h10;
  localparam logic [7:0]  GDM_RST_BYTE     = 8'h00;
  localparam int          GDM_AUX_DPLUS    = 5;
  localparam int          GDM_AUX_DMINUS   = 4;
  localparam int          GDM_AUX_OSC      = 1;
  localparam int          GDM_AUX_REG      = 0;
  localparam int          GDM_MODE_INTCLK  = 0;
  localparam int          GDM_MODE_PS2     = 1;
  localparam int          GDM_MODE_SPI     = 2;
  localparam int          GDM_SPI_LO_PIN   = 5;
  localparam int          GDM_SYNC_STAGES  = 3;
endpackage

/* rtl/gdm_top.sv */
// Purpose: Per-pin drive control for two 8-bit ports and a read-only auxiliary input port.
// Assumes: Avalon-MM slave with waitrequest; one read or write is answered in exactly two cycles.
// Notes: Pin levels pass a three-stage synchroniser; a change counts when stages two and three agree.
// Notes on behaviour
// - Reset clears data and both configuration bits, so every pin starts undriven.
// - Both configuration bits zero leaves the pin undriven regardless of data, except port zero pins under the SPI mask.
// - B=1, A=0, data 0 enables pull-down at weakest sink strength.
// - B=0, A=1, data 0 enables pull-down at medium sink strength.
// - Both bits one with data 0 enables pull-down at strongest strength.
// - A=1 with data 1 turns on only the strong pull-up.
// - B=1, A=0, data 1 enables only the resistive pull-up.
// - TTL threshold only when both bits zero and data one; otherwise CMOS.
// - Port data reads return sampled pin levels, not written values.
// - Auxiliary port is read-only and samples inputs with TTL thresholds.
// - Auxiliary bits 5 and 4 return the D+ and D- levels.
// - In internal clock mode auxiliary bit 1 returns the oscillator input level.
// - In PS/2 mode auxiliary bit 0 returns the regulator pin level.
// - Active SPI on upper three port zero pins bypasses drive; data must be one.
`timescale 1ns/1ps
module gdm_pin_sync
  import gdm_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic raw,
  output logic      level
);
  logic [GDM_SYNC_STAGES-1:0] stage;
  logic [GDM_SYNC_STAGES-1:0] next_stage;
  logic                       next_level;
  // The first stage is read only by the second stage.
  always_comb begin
    next_stage = {stage[GDM_SYNC_STAGES-2:0], raw};
    next_level = (stage[1] == stage[2]) ? stage[2] : level;
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage <= '0;
      level <= 1'b0;
    end else begin
      stage <= next_stage;
      level <= next_level;
    end
  end
endmodule // gdm_pin_sync

module gdm_top
  import gdm_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              arst_n,
  input  wire logic [GDM_AW-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [GDM_DW-1:0] avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [GDM_DW-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic [GDM_PW-1:0] port_zero_pins_in,
  output logic      [GDM_PW-1:0] port_zero_pins_out,
  output logic      [GDM_PW-1:0] port_zero_pins_oe,
  output logic      [GDM_PW-1:0] port_zero_sink_low,
  output logic      [GDM_PW-1:0] port_zero_sink_med,
  output logic      [GDM_PW-1:0] port_zero_sink_high,
  output logic      [GDM_PW-1:0] port_zero_pullup_strong,
  output logic      [GDM_PW-1:0] port_zero_pullup_res,
  output logic      [GDM_PW-1:0] port_zero_ttl_sel,
  input  wire logic [GDM_PW-1:0] port_one_pins_in,
  output logic      [GDM_PW-1:0] port_one_pins_out,
  output logic      [GDM_PW-1:0] port_one_pins_oe,
  output logic      [GDM_PW-1:0] port_one_sink_low,
  output logic      [GDM_PW-1:0] port_one_sink_med,
  output logic      [GDM_PW-1:0] port_one_sink_high,
  output logic      [GDM_PW-1:0] port_one_pullup_strong,
  output logic      [GDM_PW-1:0] port_one_pullup_res,
  output logic      [GDM_PW-1:0] port_one_ttl_sel,
  input  wire logic [2:0]        spi_out,
  input  wire logic              dplus_pin,
  input  wire logic              dminus_pin,
  input  wire logic              oscillator_input_pin,
  input  wire logic              regulator_pin
);
  localparam int NSYNC = 2 * GDM_PW + 4;

  logic [GDM_PW-1:0] data0;
  logic [GDM_PW-1:0] data1;
  logic [GDM_PW-1:0] cfg_a0;
  logic [GDM_PW-1:0] cfg_b0;
  logic [GDM_PW-1:0] cfg_a1;
  logic [GDM_PW-1:0] cfg_b1;
  logic [2:0]        mode;
  logic              busy;
  logic [GDM_DW-1:0] next_readdata;
  logic              next_waitrequest;
  logic              next_busy;
  logic [GDM_PW-1:0] next_data0;
  logic [GDM_PW-1:0] next_data1;
  logic [GDM_PW-1:0] next_cfg_a0;
  logic [GDM_PW-1:0] next_cfg_b0;
  logic [GDM_PW-1:0] next_cfg_a1;
  logic [GDM_PW-1:0] next_cfg_b1;
  logic [2:0]        next_mode;
  logic [NSYNC-1:0]  raw_in;
  logic [NSYNC-1:0]  sync_in;
  logic [GDM_PW-1:0] lvl0;
  logic [GDM_PW-1:0] lvl1;
  logic [GDM_PW-1:0] aux;
  logic [7:0]        idx;
  logic              wr_go;

  assign raw_in = {regulator_pin, oscillator_input_pin, dminus_pin, dplus_pin, port_one_pins_in, port_zero_pins_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      gdm_pin_sync u_sync (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .raw     (raw_in[gi]),
        .level   (sync_in[gi])
      );
    end
  endgenerate

  assign lvl0 = sync_in[GDM_PW-1:0];
  assign lvl1 = sync_in[2*GDM_PW-1:GDM_PW];

  // Auxiliary pins are TTL inputs; the mode bits gate bits 1 and 0, reserved bits stay zero.
  always_comb begin
    aux                 = GDM_RST_BYTE;
    aux[GDM_AUX_DPLUS]  = sync_in[2*GDM_PW];
    aux[GDM_AUX_DMINUS] = sync_in[2*GDM_PW+1];
    aux[GDM_AUX_OSC]    = mode[GDM_MODE_INTCLK] & sync_in[2*GDM_PW+2];
    aux[GDM_AUX_REG]    = mode[GDM_MODE_PS2] & sync_in[2*GDM_PW+3];
  end

  // A read is sampled in the first cycle of the request, a write in the second; both are answered with waitrequest low in the second.
  assign idx   = {2'b00, avs_address};
  assign wr_go = avs_write & busy;

  always_comb begin
    next_data0       = data0;
    next_data1       = data1;
    next_cfg_a0      = cfg_a0;
    next_cfg_b0      = cfg_b0;
    next_cfg_a1      = cfg_a1;
    next_cfg_b1      = cfg_b1;
    next_mode        = mode;
    next_busy        = (avs_read | avs_write) & ~busy;
    next_waitrequest = ~((avs_read | avs_write) & ~busy);
    next_readdata    = avs_readdata;
    if (wr_go && avs_byteenable[0]) begin
      unique case (idx)
        GDM_IDX_P0_DATA:  next_data0 = avs_writedata[GDM_PW-1:0];
        GDM_IDX_P1_DATA:  next_data1 = avs_writedata[GDM_PW-1:0];
        GDM_IDX_P0_CFG_A: next_cfg_a0 = avs_writedata[GDM_PW-1:0];
        GDM_IDX_P0_CFG_B: next_cfg_b0 = avs_writedata[GDM_PW-1:0];
        GDM_IDX_P1_CFG_A: next_cfg_a1 = avs_writedata[GDM_PW-1:0];
        GDM_IDX_P1_CFG_B: next_cfg_b1 = avs_writedata[GDM_PW-1:0];
        GDM_IDX_MODE:     next_mode = avs_writedata[2:0];
        default:          next_mode = mode;
      endcase
    end
    if (avs_read && !busy) begin
      next_readdata = '0;
      unique case (idx)
        GDM_IDX_P0_DATA: next_readdata[GDM_PW-1:0] = lvl0;
        GDM_IDX_P1_DATA: next_readdata[GDM_PW-1:0] = lvl1;
        GDM_IDX_AUX:     next_readdata[GDM_PW-1:0] = aux;
        GDM_IDX_MODE:    next_readdata[2:0] = mode;
        default:         next_readdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      data0           <= GDM_RST_BYTE;
      data1           <= GDM_RST_BYTE;
      cfg_a0          <= GDM_RST_BYTE;
      cfg_b0          <= GDM_RST_BYTE;
      cfg_a1          <= GDM_RST_BYTE;
      cfg_b1          <= GDM_RST_BYTE;
      mode            <= 3'h0;
      busy            <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end else begin
      data0           <= next_data0;
      data1           <= next_data1;
      cfg_a0          <= next_cfg_a0;
      cfg_b0          <= next_cfg_b0;
      cfg_a1          <= next_cfg_a1;
      cfg_b1          <= next_cfg_b1;
      mode            <= next_mode;
      busy            <= next_busy;
      avs_waitrequest <= next_waitrequest;
      avs_readdata    <= next_readdata;
    end
  end

  // Pin driver decode, registered so every pin control comes from a flip-flop.
  logic [GDM_PW-1:0] n_sl0, n_sm0, n_sh0, n_ps0, n_pr0, n_tt0, n_oe0, n_o0;
  logic [GDM_PW-1:0] n_sl1, n_sm1, n_sh1, n_ps1, n_pr1, n_tt1, n_oe1, n_o1;
  logic [GDM_PW-1:0] spi_mask;

  always_comb begin
    spi_mask = '0;
    if (mode[GDM_MODE_SPI]) begin
      spi_mask[GDM_PW-1:GDM_SPI_LO_PIN] = 3'b111;
    end
    n_sl0 = ~data0 & cfg_b0 & ~cfg_a0 & ~spi_mask;
    n_sm0 = ~data0 & ~cfg_b0 & cfg_a0 & ~spi_mask;
    n_sh0 = ~data0 & cfg_b0 & cfg_a0 & ~spi_mask;
    n_ps0 = data0 & cfg_a0 & ~spi_mask;
    n_pr0 = data0 & cfg_b0 & ~cfg_a0 & ~spi_mask;
    n_tt0 = data0 & ~cfg_b0 & ~cfg_a0;
    n_sl1 = ~data1 & cfg_b1 & ~cfg_a1;
    n_sm1 = ~data1 & ~cfg_b1 & cfg_a1;
    n_sh1 = ~data1 & cfg_b1 & cfg_a1;
    n_ps1 = data1 & cfg_a1;
    n_pr1 = data1 & cfg_b1 & ~cfg_a1;
    n_tt1 = data1 & ~cfg_b1 & ~cfg_a1;
    // Driven when a sink or the strong pull-up is on, or on port zero pins under the SPI mask; both bits zero otherwise leaves the pin free.
    n_oe0 = n_sl0 | n_sm0 | n_sh0 | n_ps0 | spi_mask;
    n_oe1 = n_sl1 | n_sm1 | n_sh1 | n_ps1;
    n_o0  = (n_ps0 & ~spi_mask) | (spi_mask & {spi_out, 5'h00} & data0);
    n_o1  = n_ps1;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      port_zero_sink_low      <= '0;
      port_zero_sink_med      <= '0;
      port_zero_sink_high     <= '0;
      port_zero_pullup_strong <= '0;
      port_zero_pullup_res    <= '0;
      port_zero_ttl_sel       <= '0;
      port_zero_pins_oe       <= '0;
      port_zero_pins_out      <= '0;
      port_one_sink_low       <= '0;
      port_one_sink_med       <= '0;
      port_one_sink_high      <= '0;
      port_one_pullup_strong  <= '0;
      port_one_pullup_res     <= '0;
      port_one_ttl_sel        <= '0;
      port_one_pins_oe        <= '0;
      port_one_pins_out       <= '0;
    end else begin
      port_zero_sink_low      <= n_sl0;
      port_zero_sink_med      <= n_sm0;
      port_zero_sink_high     <= n_sh0;
      port_zero_pullup_strong <= n_ps0;
      port_zero_pullup_res    <= n_pr0;
      port_zero_ttl_sel       <= n_tt0;
      port_zero_pins_oe       <= n_oe0;
      port_zero_pins_out      <= n_o0;
      port_one_sink_low       <= n_sl1;
      port_one_sink_med       <= n_sm1;
      port_one_sink_high      <= n_sh1;
      port_one_pullup_strong  <= n_ps1;
      port_one_pullup_res     <= n_pr1;
      port_one_ttl_sel        <= n_tt1;
      port_one_pins_oe        <= n_oe1;
      port_one_pins_out       <= n_o1;
    end
  end

  property p_hiz_both_zero;
    @(posedge ref_clk) disable iff (!arst_n)
      1'b1 |=> ((port_one_pins_oe & ~$past(cfg_a1 | cfg_b1)) == 8'h00);
  endproperty
  a_hiz_both_zero: assert property (p_hiz_both_zero) else $error("pin driven with both config bits zero");

  property p_low_sink;
    @(posedge ref_clk) disable iff (!arst_n)
      1'b1 |=> (port_one_sink_low == $past(~data1 & cfg_b1 & ~cfg_a1));
  endproperty
  a_low_sink: assert property (p_low_sink) else $error("low sink decode wrong");

  property p_med_sink;
    @(posedge ref_clk) disable iff (!arst_n)
      1'b1 |=> (port_one_sink_med == $past(~data1 & ~cfg_b1 & cfg_a1));
  endproperty
  a_med_sink: assert property (p_med_sink) else $error("medium sink decode wrong");

  property p_high_sink;
    @(posedge ref_clk) disable iff (!arst_n)
      1'b1 |=> (port_one_sink_high == $past(~data1 & cfg_b1 & cfg_a1));
  endproperty
  a_high_sink: assert property (p_high_sink) else $error("high sink decode wrong");

  property p_strong_up;
    @(posedge ref_clk) disable iff (!arst_n)
      1'b1 |=> ((port_one_pullup_strong & (port_one_sink_low | port_one_sink_med | port_one_sink_high
                 | port_one_pullup_res)) == 8'h00) && (port_one_pullup_strong == $past(data1 & cfg_a1));
  endproperty
  a_strong_up: assert property (p_strong_up) else $error("strong pull-up wrong or overlaps");

  property p_res_up;
    @(posedge ref_clk) disable iff (!arst_n)
      1'b1 |=> ((port_one_pullup_res & port_one_pins_oe) == 8'h00)
        && (port_one_pullup_res == $past(data1 & cfg_b1 & ~cfg_a1));
  endproperty
  a_res_up: assert property (p_res_up) else $error("resistive pull-up wrong");

  property p_ttl;
    @(posedge ref_clk) disable iff (!arst_n)
      1'b1 |=> (port_zero_ttl_sel == $past(data0 & ~cfg_b0 & ~cfg_a0));
  endproperty
  a_ttl: assert property (p_ttl) else $error("threshold select wrong");

  property p_aux_reserved;
    @(posedge ref_clk) disable iff (!arst_n)
      (avs_read && !busy && idx == GDM_IDX_AUX)
        |=> (avs_readdata[7:6] == 2'b00 && avs_readdata[3:2] == 2'b00 && !avs_waitrequest);
  endproperty
  a_aux_reserved: assert property (p_aux_reserved) else $error("auxiliary reserved bits not zero");

  property p_cfg_read_zero;
    @(posedge ref_clk) disable iff (!arst_n)
      (avs_read && !busy && (idx == GDM_IDX_P0_CFG_A || idx == GDM_IDX_P0_CFG_B
        || idx == GDM_IDX_P1_CFG_A || idx == GDM_IDX_P1_CFG_B)) |=> (avs_readdata == 32'h0000_0000);
  endproperty
  a_cfg_read_zero: assert property (p_cfg_read_zero) else $error("config read not zero");

  property p_reg_gate;
    @(posedge ref_clk) disable iff (!arst_n)
      (!mode[GDM_MODE_PS2] && avs_read && !busy && idx == GDM_IDX_AUX) |=> (avs_readdata[0] == 1'b0);
  endproperty
  a_reg_gate: assert property (p_reg_gate) else $error("regulator bit visible outside PS/2 mode");

  property p_spi_bypass;
    @(posedge ref_clk) disable iff (!arst_n)
      mode[GDM_MODE_SPI] |=> (port_zero_pins_oe[GDM_PW-1:GDM_SPI_LO_PIN] == 3'b111)
        && (port_zero_pins_out[GDM_PW-1:GDM_SPI_LO_PIN] == ($past(spi_out) & $past(data0[GDM_PW-1:GDM_SPI_LO_PIN])));
  endproperty
  a_spi_bypass: assert property (p_spi_bypass) else $error("SPI pins not bypassed");

  property p_pin_read;
    @(posedge ref_clk) disable iff (!arst_n)
      (avs_read && !busy && idx == GDM_IDX_P1_DATA)
        |=> (avs_readdata == {{(GDM_DW-GDM_PW){1'b0}}, $past(lvl1)});
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("port data read not the pin level");
endmodule // gdm_top

/* verif/gdm_pin_load.sv */
// Purpose: Board-side model of one 8-bit port: pin levels seen by the block.
// Assumes: Driven pins follow the block; released pins follow the board or a pull-up.
// Notes: A floating pin toggles every cycle, so stages two and three never agree and the synchroniser holds its last level.
`timescale 1ns/1ps
module gdm_pin_load (
  input  wire logic       ref_clk,
  input  wire logic [7:0] pins_out,
  input  wire logic [7:0] pins_oe,
  input  wire logic [7:0] pullup_res,
  input  wire logic [7:0] board_val,
  input  wire logic       board_en,
  output logic      [7:0] pins_in
);
  logic [7:0] float_pat = 8'h5A;
  always @(posedge ref_clk) float_pat <= ~float_pat;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pins_oe[i]) pins_in[i] = pins_out[i];
      else if (board_en) pins_in[i] = board_val[i];
      else if (pullup_res[i]) pins_in[i] = 1'b1;
      else pins_in[i] = float_pat[i];
    end
  end
endmodule // gdm_pin_load

/* verif/test_gdm_top.sv */
// Purpose: Self-checking bench for the drive mode and auxiliary input block.
// Assumes: Avalon-MM master waits for waitrequest low; pin inputs pass a synchroniser.
// Notes: Expected drive outputs come from a truth-table model in the bench.
`timescale 1ns/1ps
module test_gdm_top;
  import gdm_pkg::*;
  logic ref_clk, arst_n, avs_read, avs_write, board_en, dp, dm, osc, rg;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, rd, rnd;
  logic [3:0] avs_byteenable;
  logic [2:0] spi_out;
  logic [7:0] bv0, bv1;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest;
  wire logic [7:0] z_in, z_out, z_oe, z_sl, z_sm, z_sh, z_ps, z_pr, z_tt;
  wire logic [7:0] o_in, o_out, o_oe, o_sl, o_sm, o_sh, o_ps, o_pr, o_tt;
  wire logic [63:0] obs0 = {z_oe, z_out, z_sl, z_sm, z_sh, z_ps, z_pr, z_tt};
  wire logic [63:0] obs1 = {o_oe, o_out, o_sl, o_sm, o_sh, o_ps, o_pr, o_tt};
  int failures = 0;
  int checks_done = 0;
  gdm_pin_load u_load0 (.ref_clk(ref_clk), .pins_out(z_out), .pins_oe(z_oe), .pullup_res(z_pr),
    .board_val(bv0), .board_en(board_en), .pins_in(z_in));
  gdm_pin_load u_load1 (.ref_clk(ref_clk), .pins_out(o_out), .pins_oe(o_oe), .pullup_res(o_pr),
    .board_val(bv1), .board_en(board_en), .pins_in(o_in));
  gdm_top dut (.ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .port_zero_pins_in(z_in), .port_zero_pins_out(z_out), .port_zero_pins_oe(z_oe),
    .port_zero_sink_low(z_sl), .port_zero_sink_med(z_sm), .port_zero_sink_high(z_sh),
    .port_zero_pullup_strong(z_ps), .port_zero_pullup_res(z_pr), .port_zero_ttl_sel(z_tt),
    .port_one_pins_in(o_in), .port_one_pins_out(o_out), .port_one_pins_oe(o_oe),
    .port_one_sink_low(o_sl), .port_one_sink_med(o_sm), .port_one_sink_high(o_sh),
    .port_one_pullup_strong(o_ps), .port_one_pullup_res(o_pr), .port_one_ttl_sel(o_tt),
    .spi_out(spi_out), .dplus_pin(dp), .dminus_pin(dm), .oscillator_input_pin(osc),
    .regulator_pin(rg));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Truth table model: {oe, out, sink low, med, high, strong up, resistive up, ttl}.
  function automatic logic [63:0] drv(input logic [7:0] dd, input logic [7:0] aa, input logic [7:0] bb);
    drv = {aa | (bb & ~dd), aa & dd, bb & ~aa & ~dd, ~bb & aa & ~dd, bb & aa & ~dd, aa & dd,
           bb & ~aa & dd, ~aa & ~bb & dd};
  endfunction
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= idx[5:0];
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h000000, wd};
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk("bus timeout", 64'h1, 64'h0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic setport(input bit p, input logic [7:0] dd, input logic [7:0] aa, input logic [7:0] bb);
    bus(1'b1, p ? GDM_IDX_P1_DATA : GDM_IDX_P0_DATA, dd);
    bus(1'b1, p ? GDM_IDX_P1_CFG_A : GDM_IDX_P0_CFG_A, aa);
    bus(1'b1, p ? GDM_IDX_P1_CFG_B : GDM_IDX_P0_CFG_B, bb);
    repeat (3) @(posedge ref_clk);
    chk(p ? "port one drive" : "port zero drive", p ? obs1 : obs0, drv(dd, aa, bb));
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    summarize;
  end
  initial begin
    {arst_n, avs_read, avs_write, board_en, dp, dm, osc, rg} = 8'h00;
    avs_address = 6'h00;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h1;
    spi_out = 3'h0;
    {bv0, bv1} = 16'h0000;
    rnd = 32'h21F4F50C;
    repeat (2) @(posedge ref_clk);
    chk("reset port zero", obs0, 64'h0);
    chk("reset port one", obs1, 64'h0);
    chk("reset waitrequest", {63'h0, avs_waitrequest}, 64'h1);
    arst_n <= 1'b1;
    bus(1'b0, GDM_IDX_P0_CFG_A, 8'h00);
    chk("cfg read", rd, 64'h0);
    $display("test reset done");
    setport(1'b0, 8'hAA, 8'hCC, 8'hF0);
    for (int k = 0; k < 6; k++) begin
      rnd = lfsr(lfsr(lfsr(rnd)));
      setport(k[0], rnd[7:0], rnd[15:8], rnd[23:16]);
      bus(1'b0, k[0] ? GDM_IDX_P1_CFG_B : GDM_IDX_P0_CFG_B, 8'h00);
      chk("cfg b read", rd, 64'h0);
    end
    for (int k = 0; k < 2; k++) setport(1'b0, 8'h00, k[0] ? 8'h0F : 8'h00, 8'h00);
    $display("test drive done");
    @(posedge ref_clk);
    arst_n <= 1'b0;
    @(posedge ref_clk);
    chk("second reset port zero", obs0, 64'h0);
    chk("second reset port one", obs1, 64'h0);
    arst_n <= 1'b1;
    avs_byteenable <= 4'hE;
    bus(1'b1, GDM_IDX_P0_CFG_A, 8'hFF);
    avs_byteenable <= 4'h1;
    repeat (3) @(posedge ref_clk);
    chk("lane off write", obs0, 64'h0);
    bus(1'b1, GDM_IDX_P0_CFG_A, 8'hFF);
    repeat (3) @(posedge ref_clk);
    chk("data cleared by reset", obs0, drv(8'h00, 8'hFF, 8'h00));
    $display("test second reset done");
    setport(1'b0, 8'h00, 8'h00, 8'h00);
    setport(1'b1, 8'h00, 8'h00, 8'h00);
    rnd = lfsr(rnd);
    bv0 <= rnd[7:0];
    bv1 <= rnd[15:8];
    board_en <= 1'b1;
    bus(1'b1, GDM_IDX_P0_DATA, ~rnd[7:0]);
    repeat (8) @(posedge ref_clk);
    bus(1'b0, GDM_IDX_P0_DATA, 8'h00);
    chk("port zero read", rd, {56'h0, bv0});
    bus(1'b0, GDM_IDX_P1_DATA, 8'h00);
    chk("port one read", rd, {56'h0, bv1});
    board_en <= 1'b0;
    $display("test pin read done");
    for (int m = 0; m < 4; m++) begin
      rnd = lfsr(rnd);
      {dp, dm, osc, rg} <= rnd[3:0];
      bus(1'b1, GDM_IDX_MODE, m[7:0]);
      repeat (8) @(posedge ref_clk);
      bus(1'b1, GDM_IDX_AUX, 8'hFF);
      bus(1'b0, GDM_IDX_AUX, 8'h00);
      chk("aux read", rd, {58'h0, dp, dm, 2'b00, osc & m[0], rg & m[1]});
    end
    $display("test aux done");
    bus(1'b1, GDM_IDX_MODE, 8'h04);
    bus(1'b1, GDM_IDX_P0_DATA, 8'hA0);
    spi_out <= 3'b111;
    repeat (4) @(posedge ref_clk);
    chk("spi pins", {z_oe[7:5], z_out[7:5], z_sl[7:5] | z_ps[7:5]}, {3'b111, 3'b101, 3'b000});
    bus(1'b0, 8'h3F, 8'h00);
    chk("unmapped read", rd, 64'h0);
    $display("test spi done");
    summarize;
  end
endmodule // test_gdm_top
